// ==== design/gpm_port_top.v ====
// five 8-bit ports with per-pin mode select on the special-function bus
`include "gpm_defs.vh"
module gpm_port_top (
    // clock and reset
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire clk_en_i,
    // straps and power state
    input wire tristate_fuse_i,
    input wire power_down_i,
    input wire [7:0] p1_gp_irq_en_i,
    input wire [1:0] clk_src_i,
    input wire reset_pin_en_i,
    // special-function register port
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire [7:0] sfr_wdata_i,
    input wire sfr_rd_i,
    input wire sfr_rd_latch_i,
    output reg [7:0] sfr_rdata_o,
    output reg sfr_hit_o,
    // pins, as pad controls
    input wire [`GPM_NPIN-1:0] pin_i,
    output reg [`GPM_NPIN-1:0] pin_drive_low_o,
    output reg [`GPM_NPIN-1:0] pin_strong_up_o,
    output reg [`GPM_NPIN-1:0] pin_weak_up_o,
    output reg [`GPM_NPIN-1:0] pin_very_weak_up_o,
    output reg [`GPM_NPIN-1:0] pin_oe_o,
    output reg [`GPM_NPIN-1:0] pin_in_o,
    output reg [5:0] pin_count_o
);
    reg [`GPM_NPIN-1:0] latch_q;
    reg [`GPM_NPIN-1:0] msa_q;
    reg [`GPM_NPIN-1:0] msb_q;
    reg [`GPM_NPIN-1:0] sync1_q;
    reg [`GPM_NPIN-1:0] sync2_q;
    reg rst_seen_q;
    wire [`GPM_NPIN-1:0] in_en;
    wire [`GPM_NPIN-1:0] c_low;
    wire [`GPM_NPIN-1:0] c_strong;
    wire [`GPM_NPIN-1:0] c_weak;
    wire [`GPM_NPIN-1:0] c_vweak;
    wire [`GPM_NPIN-1:0] c_in;
    reg [2:0] wsel;
    reg wdata_hit;
    reg wmsa;
    reg wmsb;

    //////////////////////////////////////////////////////////////////////
    // address decode
    always @* begin
        wsel = 3'h0;
        wdata_hit = 1'b0;
        wmsa = 1'b0;
        wmsb = 1'b0;
        case (sfr_addr_i)
            `GPM_ADDR_P0_DATA: begin wsel = 3'h0; wdata_hit = 1'b1; end
            `GPM_ADDR_P1_DATA: begin wsel = 3'h1; wdata_hit = 1'b1; end
            `GPM_ADDR_P2_DATA: begin wsel = 3'h2; wdata_hit = 1'b1; end
            `GPM_ADDR_P3_DATA: begin wsel = 3'h3; wdata_hit = 1'b1; end
            `GPM_ADDR_P4_DATA: begin wsel = 3'h4; wdata_hit = 1'b1; end
            `GPM_ADDR_P0_MSA: begin wsel = 3'h0; wmsa = 1'b1; end
            `GPM_ADDR_P0_MSB: begin wsel = 3'h0; wmsb = 1'b1; end
            `GPM_ADDR_P1_MSA: begin wsel = 3'h1; wmsa = 1'b1; end
            `GPM_ADDR_P1_MSB: begin wsel = 3'h1; wmsb = 1'b1; end
            `GPM_ADDR_P2_MSA: begin wsel = 3'h2; wmsa = 1'b1; end
            `GPM_ADDR_P2_MSB: begin wsel = 3'h2; wmsb = 1'b1; end
            `GPM_ADDR_P3_MSA: begin wsel = 3'h3; wmsa = 1'b1; end
            `GPM_ADDR_P3_MSB: begin wsel = 3'h3; wmsb = 1'b1; end
            `GPM_ADDR_P4_MSA: begin wsel = 3'h4; wmsa = 1'b1; end
            `GPM_ADDR_P4_MSB: begin wsel = 3'h4; wmsb = 1'b1; end
            default: begin wsel = 3'h0; end
        endcase
    end

    //////////////////////////////////////////////////////////////////////
    // port registers; reset mode taken from the fuse one edge after release
    // so the fuse is never sampled under the asynchronous reset
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            latch_q <= {`GPM_NPORT{`GPM_LATCH_RST}};
            // analog pins and, until the fuse is sampled, all pins input-only
            msa_q <= {`GPM_NPORT{`GPM_ALL_ONES}};
            msb_q <= {`GPM_NPORT{`GPM_ALL_ZERO}};
            rst_seen_q <= 1'b0;
        end else if (clk_en_i) begin
            if (!rst_seen_q) begin
                rst_seen_q <= 1'b1;
                if (tristate_fuse_i) begin
                    msa_q <= {`GPM_NPORT{`GPM_ALL_ONES}};
                end else begin
                    // non-analog pins quasi, latch already one so weakly high
                    msa_q <= {`GPM_ALL_ZERO, `GPM_ALL_ZERO, `GPM_ANALOG_P2, `GPM_ALL_ZERO,
                              `GPM_ANALOG_P0};
                end
            end else if (sfr_wr_i) begin
                // a write in the fuse-sample cycle is dropped; see hand-over
                if (wdata_hit) begin
                    latch_q[wsel*8 +: 8] <= sfr_wdata_i;
                end
                if (wmsa) begin
                    msa_q[wsel*8 +: 8] <= sfr_wdata_i;
                end
                if (wmsb) begin
                    msb_q[wsel*8 +: 8] <= sfr_wdata_i;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // pin synchroniser; only the second stage is read
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_q <= {`GPM_NPIN{1'b1}};
            sync2_q <= {`GPM_NPIN{1'b1}};
        end else if (clk_en_i) begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
        end
    end

    // input enables: in power-down only wake pins and enabled p1 irq pins
    assign in_en = power_down_i ?
        {`GPM_WAKE_P4, `GPM_WAKE_P3, `GPM_ALL_ZERO, p1_gp_irq_en_i, `GPM_ALL_ZERO} :
        {`GPM_NPIN{1'b1}};

    //////////////////////////////////////////////////////////////////////
    // per-pin cells
    genvar gi;
    generate
        for (gi = 0; gi < `GPM_NPIN; gi = gi + 1) begin : g_pin
            gpm_pin_cell u_cell (
                .clk_sys_i(clk_sys_i),
                .sys_rst_i(sys_rst_i),
                .clk_en_i(clk_en_i),
                .latch_i(latch_q[gi]),
                .mode_a_i(msa_q[gi]),
                .mode_b_i(msb_q[gi]),
                .in_enable_i(in_en[gi]),
                .pin_sync_i(sync2_q[gi]),
                .drive_low_o(c_low[gi]),
                .strong_up_o(c_strong[gi]),
                .weak_up_o(c_weak[gi]),
                .very_weak_up_o(c_vweak[gi]),
                .in_value_o(c_in[gi])
            );
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////
    // outputs registered once more so every top output is a flop
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_drive_low_o <= {`GPM_NPIN{1'b0}};
            pin_strong_up_o <= {`GPM_NPIN{1'b0}};
            pin_weak_up_o <= {`GPM_NPIN{1'b0}};
            pin_very_weak_up_o <= {`GPM_NPIN{1'b0}};
            pin_oe_o <= {`GPM_NPIN{1'b0}};
            pin_in_o <= {`GPM_NPIN{1'b1}};
            pin_count_o <= `GPM_PINS_MIN;
        end else if (clk_en_i) begin
            pin_drive_low_o <= c_low;
            pin_strong_up_o <= c_strong;
            pin_weak_up_o <= c_weak;
            pin_very_weak_up_o <= c_vweak;
            pin_oe_o <= c_low | c_strong; // strong drive only; weak pulls are resistive
            pin_in_o <= c_in;
            // crystal 0, external clock 1, internal rc 2; no reset pin adds one
            pin_count_o <= `GPM_PINS_MIN + {4'h0, (clk_src_i == 2'h3) ? 2'h2 : clk_src_i}
                           + {5'h0, ~reset_pin_en_i};
        end
    end

    // read path: plain read sees pins, read-modify-write sees latch
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sfr_rdata_o <= `GPM_ALL_ZERO;
            sfr_hit_o <= 1'b0;
        end else if (clk_en_i) begin
            sfr_hit_o <= sfr_rd_i & (wdata_hit | wmsa | wmsb);
            if (!sfr_rd_i) begin
                sfr_rdata_o <= `GPM_ALL_ZERO;
            end else if (wdata_hit) begin
                sfr_rdata_o <= sfr_rd_latch_i ? latch_q[wsel*8 +: 8] : c_in[wsel*8 +: 8];
            end else if (wmsa) begin
                sfr_rdata_o <= msa_q[wsel*8 +: 8];
            end else if (wmsb) begin
                sfr_rdata_o <= msb_q[wsel*8 +: 8];
            end else begin
                sfr_rdata_o <= `GPM_ALL_ZERO; // unmapped reads zero
            end
        end
    end
endmodule // gpm_port_top

// ==== design/gpm_defs.vh ====
// constants for the configurable gpio port block
// Overview of operation
// - mode bits a,b: 00 quasi, 01 push-pull, 10 input-only, 11 open-drain.
// - tristate fuse enabled resets every pin to input-only.
// - fuse disabled resets non-analog pins to quasi-bidirectional, weakly pulled high.
// - analog pins (port 0, port 2 bits 4-7) always reset input-only.
// - every pin input passes a schmitt-style filtered buffer.
// - power-down disables inputs except irq a/b, reset and oscillator pins.
// - port 1 pins enabled as general interrupts keep input alive in power-down.
// - usable pin count 35 to 38 depends on clock source and reset option.
// - quasi pin is both input and output; high is driven weakly, and strongly only for the pulse after a latch zero-to-one.
// - quasi pin with latch zero is driven strongly low.
// - quasi very weak pull-up on whenever latch holds one.
// - quasi weak pull-up on only while latch one and pin reads high.
// - quasi latch zero-to-one turns strong pull-up on for exactly two clocks.
// - input-only mode disables all output drivers.
// - data and mode registers decoded at fixed special-function addresses.
// - port 4 mode registers at be/bf, data at c0.
// - push-pull drives strongly high on latch one, low on zero.
// - open-drain has no pull-ups, drives low only when latch zero.
`ifndef GPM_DEFS_VH
`define GPM_DEFS_VH
`define GPM_ADDR_P0_DATA 8'h80
`define GPM_ADDR_P1_DATA 8'h90
`define GPM_ADDR_P2_DATA 8'ha0
`define GPM_ADDR_P3_DATA 8'hb0
`define GPM_ADDR_P4_DATA 8'hc0
`define GPM_ADDR_P0_MSA 8'hba
`define GPM_ADDR_P0_MSB 8'hbb
`define GPM_ADDR_P1_MSA 8'hc2
`define GPM_ADDR_P1_MSB 8'hc3
`define GPM_ADDR_P2_MSA 8'hc4
`define GPM_ADDR_P2_MSB 8'hc5
`define GPM_ADDR_P3_MSA 8'hc6
`define GPM_ADDR_P3_MSB 8'hc7
`define GPM_ADDR_P4_MSA 8'hbe
`define GPM_ADDR_P4_MSB 8'hbf
`define GPM_NPORT 5
`define GPM_NPIN 40
`define GPM_LATCH_RST 8'hff
`define GPM_ANALOG_P0 8'hff
`define GPM_ANALOG_P2 8'hf0
`define GPM_ALL_ONES 8'hff
`define GPM_ALL_ZERO 8'h00
`define GPM_STRONG_CNT 2'h2
`define GPM_FILT_LEN 3
// always-awake pins: irq a/b at p3.2/3.3, osc in/out p4.0/4.1, reset p4.2
`define GPM_WAKE_P3 8'h0c
`define GPM_WAKE_P4 8'h07
`define GPM_PINS_MIN 6'h23
`endif

// ==== design/gpm_pin_cell.v ====
// one pin: mode decode, drivers, pull-ups, strong pulse and input filter
`include "gpm_defs.vh"
module gpm_pin_cell (
    // clock and reset
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire clk_en_i,
    // configuration
    input wire latch_i,
    input wire mode_a_i,
    input wire mode_b_i,
    input wire in_enable_i,
    // pin side
    input wire pin_sync_i,
    output reg drive_low_o,
    output reg strong_up_o,
    output reg weak_up_o,
    output reg very_weak_up_o,
    output reg in_value_o
);
    localparam MODE_QUASI = 2'b00;
    localparam MODE_PUSH = 2'b01;
    localparam MODE_INPUT = 2'b10;
    localparam MODE_OPEN = 2'b11;

    wire [1:0] mode = {mode_a_i, mode_b_i};
    reg latch_prev_q;
    reg [1:0] pulse_cnt_q;
    reg [`GPM_FILT_LEN-1:0] hist_q;

    // strong pull-up pulse counter on a rising latch in quasi mode
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            latch_prev_q <= 1'b1;
            pulse_cnt_q <= 2'h0;
        end else if (clk_en_i) begin
            latch_prev_q <= latch_i;
            if (mode == MODE_QUASI && latch_i && !latch_prev_q) begin
                // the edge cycle itself is the first of the strong cycles
                pulse_cnt_q <= `GPM_STRONG_CNT - 2'h1;
            end else if (pulse_cnt_q != 2'h0) begin
                pulse_cnt_q <= pulse_cnt_q - 2'h1;
            end
        end
    end

    // hysteresis: value flips only after a run of equal samples, a noise filter
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hist_q <= {`GPM_FILT_LEN{1'b1}};
            in_value_o <= 1'b1;
        end else if (clk_en_i) begin
            hist_q <= {hist_q[`GPM_FILT_LEN-2:0], pin_sync_i & in_enable_i};
            if (&hist_q) begin
                in_value_o <= 1'b1;
            end else if (~|hist_q) begin
                in_value_o <= 1'b0;
            end
        end
    end

    // drivers registered so pad controls come from flops
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            drive_low_o <= 1'b0;
            strong_up_o <= 1'b0;
            weak_up_o <= 1'b0;
            very_weak_up_o <= 1'b0;
        end else if (clk_en_i) begin
            drive_low_o <= 1'b0;
            strong_up_o <= 1'b0;
            weak_up_o <= 1'b0;
            very_weak_up_o <= 1'b0;
            case (mode)
                MODE_QUASI: begin
                    drive_low_o <= ~latch_i;
                    very_weak_up_o <= latch_i;
                    weak_up_o <= latch_i & pin_sync_i;
                    strong_up_o <= latch_i && (pulse_cnt_q != 2'h0 || !latch_prev_q);
                end
                MODE_PUSH: begin
                    drive_low_o <= ~latch_i;
                    strong_up_o <= latch_i;
                end
                MODE_OPEN: begin
                    drive_low_o <= ~latch_i;
                end
                default: begin
                    drive_low_o <= 1'b0;
                end
            endcase
        end
    end
endmodule // gpm_pin_cell

// ==== sim/gpm_port_top_sva.sv ====
// checker for the gpio port block pads, pin count and read port
module gpm_port_sva (
    // clock and reset
    input wire clk_sys_i,
    input wire sys_rst_i,
    // straps and power state
    input wire power_down_i,
    input wire [7:0] p1_gp_irq_en_i,
    input wire [1:0] clk_src_i,
    input wire reset_pin_en_i,
    // register port
    input wire [7:0] sfr_addr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_rdata_o,
    input wire sfr_hit_o,
    // pads
    input wire [39:0] pin_drive_low_o,
    input wire [39:0] pin_strong_up_o,
    input wire [39:0] pin_weak_up_o,
    input wire [39:0] pin_very_weak_up_o,
    input wire [39:0] pin_oe_o,
    input wire [39:0] pin_in_o,
    input wire [5:0] pin_count_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    logic [4:0] pd_cnt_q;
    logic [39:0] wake;
    ////////////////////////////////////////////////////////////////////////
    // power-down run length; saturates so long sleeps stay covered
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i || !power_down_i) pd_cnt_q <= 5'h00;
        else if (pd_cnt_q != 5'h1f) pd_cnt_q <= pd_cnt_q + 5'h01;
    end
    // inputs allowed to stay alive while asleep
    assign wake = {8'h07, 8'h0c, 8'h00, p1_gp_irq_en_i, 8'h00};
    sequence s_rd_map;
        sfr_rd_i && (sfr_addr_i inside {8'h80, 8'h90, 8'ha0, 8'hb0, 8'hc0, 8'hba, 8'hbb, 8'hbe, 8'hbf,
            [8'hc2:8'hc7]});
    endsequence
    sequence s_rd_unmap;
        sfr_rd_i && !(sfr_addr_i inside {8'h80, 8'h90, 8'ha0, 8'hb0, 8'hc0, 8'hba, 8'hbb, 8'hbe, 8'hbf,
            [8'hc2:8'hc7]});
    endsequence
    property p_oe; pin_oe_o == (pin_drive_low_o | pin_strong_up_o); endproperty
    property p_lowpull; (pin_drive_low_o & (pin_strong_up_o | pin_weak_up_o | pin_very_weak_up_o)) == 40'h0;
    endproperty
    property p_weak; (pin_weak_up_o & ~pin_very_weak_up_o) == 40'h0; endproperty
    property p_cnt; 1'b1 |=> pin_count_o == 6'h23 + {5'h00, $past(clk_src_i) != 2'h0}
        + {5'h00, $past(clk_src_i[1])} + {5'h00, !$past(reset_pin_en_i)}; endproperty
    property p_map; s_rd_map |=> sfr_hit_o; endproperty
    property p_unmap; s_rd_unmap |=> sfr_rdata_o == 8'h00 && !sfr_hit_o; endproperty
    property p_idle; !sfr_rd_i |=> sfr_rdata_o == 8'h00 && !sfr_hit_o; endproperty
    property p_pd; pd_cnt_q >= 5'h0c |-> (pin_in_o & ~wake) == 40'h0; endproperty
    a_oe: assert property (p_oe) else $error("oe differs from drivers");
    a_lowpull: assert property (p_lowpull) else $error("pull-down with pull-up");
    a_weak: assert property (p_weak) else $error("weak without very weak");
    a_cnt: assert property (p_cnt) else $error("pin count wrong");
    a_map: assert property (p_map) else $error("mapped read missed");
    a_unmap: assert property (p_unmap) else $error("unmapped read answered");
    a_idle: assert property (p_idle) else $error("read data without read");
    a_pd: assert property (p_pd) else $error("input alive in power-down");
endmodule // gpm_port_sva

bind gpm_port_top gpm_port_sva u_sva (.clk_sys_i, .sys_rst_i, .power_down_i, .p1_gp_irq_en_i, .clk_src_i,
    .reset_pin_en_i, .sfr_addr_i, .sfr_rd_i, .sfr_rdata_o, .sfr_hit_o, .pin_drive_low_o, .pin_strong_up_o,
    .pin_weak_up_o, .pin_very_weak_up_o, .pin_oe_o, .pin_in_o, .pin_count_o);

// ==== sim/gpm_pin_env.sv ====
// external circuits on the forty port pins
module gpm_pin_env (
    // clock
    input wire clk_sys_i,
    // pad controls from the block
    input wire [39:0] drive_low_i,
    input wire [39:0] pull_up_i,
    // outside pull-down per pin
    input wire [39:0] ext_low_i,
    // pad levels
    output logic [39:0] pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic tog_q = 1'b0;
    // an undriven pin wanders so it never reads as a clean level
    always @(posedge clk_sys_i) tog_q <= ~tog_q;
    // outside pull-down beats the weak pull-ups
    always_comb begin
        for (int i = 0; i < 40; i++) begin
            if (drive_low_i[i] || ext_low_i[i]) pin_o[i] = 1'b0;
            else if (pull_up_i[i]) pin_o[i] = 1'b1;
            else pin_o[i] = tog_q;
        end
    end
endmodule // gpm_pin_env

// ==== sim/gpm_port_mode_config_tb.sv ====
// self-checking bench for the gpio port block
module gpm_port_mode_config_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1, tristate_fuse_i = 1'b0, power_down_i = 1'b0;
    logic [7:0] p1_gp_irq_en_i = 8'h00, sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00;
    logic [1:0] clk_src_i = 2'h0;
    logic reset_pin_en_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, sfr_rd_latch_i = 1'b1;
    logic [39:0] ext_low = 40'h0, pin_i;
    wire [7:0] sfr_rdata_o;
    wire sfr_hit_o;
    wire [39:0] lo, su, wu, vw, oe, pin_in;
    wire [5:0] pin_count_o;
    int err_count = 0, comparisons = 0, n;
    always #12.5 clk_sys_i = ~clk_sys_i;
    gpm_port_top dut (.clk_sys_i, .sys_rst_i, .clk_en_i, .tristate_fuse_i, .power_down_i, .p1_gp_irq_en_i,
        .clk_src_i, .reset_pin_en_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i, .sfr_rd_latch_i,
        .sfr_rdata_o, .sfr_hit_o, .pin_i, .pin_drive_low_o(lo), .pin_strong_up_o(su), .pin_weak_up_o(wu),
        .pin_very_weak_up_o(vw), .pin_oe_o(oe), .pin_in_o(pin_in), .pin_count_o);
    gpm_pin_env env (.clk_sys_i, .drive_low_i(lo), .pull_up_i(su | wu | vw), .ext_low_i(ext_low), .pin_o(pin_i));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
        #2;
    endtask
    // write strobe held for exactly one edge
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        cyc(1);
        sfr_wr_i = 1'b0;
    endtask
    // read data stands for one cycle after the read edge
    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        cyc(1);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        cyc(1);
        sfr_rd_i = 1'b0;
        chk(sfr_rdata_o, exp);
        chk(sfr_hit_o, hit);
    endtask
    task automatic do_reset(input logic fuse);
        sys_rst_i = 1'b1;
        tristate_fuse_i = fuse;
        cyc(10);
        sys_rst_i = 1'b0;
        cyc(4);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(1'b0);
        chk({vw[23:0], oe[7:0]}, 40'h0fff0000);
        sfr_rd(8'hba, 8'hff, 1'b1);
        sfr_rd(8'hbb, 8'h00, 1'b1);
        sfr_rd(8'hc4, 8'hf0, 1'b1);
        sfr_rd(8'hbe, 8'h00, 1'b1);
        sfr_rd(8'hc0, 8'hff, 1'b1);
        sfr_rd(8'h91, 8'h00, 1'b0);
        $display("reset and decode test done");
        sfr_wr(8'h90, 8'h00);
        cyc(2);
        chk(lo[15:8], 8'hff);
        sfr_wr(8'h90, 8'hff);
        n = 0;
        for (int i = 0; i < 8; i++) begin
            if (su[8] === 1'b1) n++;
            cyc(1);
        end
        chk(n, 2);
        // pins held low outside while latch is one: plain read sees pins
        ext_low[15:12] = 4'hf;
        cyc(6);
        sfr_rd_latch_i = 1'b0;
        sfr_rd(8'h90, 8'h0f, 1'b1);
        sfr_rd_latch_i = 1'b1;
        sfr_rd(8'h90, 8'hff, 1'b1);
        ext_low[15:12] = 4'h0;
        cyc(1);
        // frozen by the clock enable, a write must not land
        clk_en_i = 1'b0;
        sfr_wr(8'h90, 8'h00);
        cyc(2);
        chk(lo[15:8], 8'h00);
        clk_en_i = 1'b1;
        $display("quasi drive test done");
        sfr_wr(8'hc2, 8'h06);
        sfr_wr(8'hc3, 8'h03);
        sfr_wr(8'h90, 8'hf8);
        cyc(2);
        chk({lo[8], lo[9], oe[10], vw[11], su[9] | wu[9] | vw[9]}, 5'b11010);
        sfr_wr(8'h90, 8'hff);
        cyc(6);
        chk({su[8], lo[9], wu[9], vw[9], su[9], oe[10]}, 6'b100000);
        ext_low[11] = 1'b1;
        cyc(10);
        chk({wu[11], vw[11], pin_in[11]}, 3'b010);
        ext_low[11] = 1'b0;
        $display("mode test done");
        p1_gp_irq_en_i = 8'h10;
        power_down_i = 1'b1;
        cyc(16);
        chk({pin_in[26], pin_in[12], pin_in[24]}, 3'b110);
        power_down_i = 1'b0;
        $display("power-down test done");
        do_reset(1'b1);
        chk(oe | vw | wu, 40'h0);
        sfr_rd(8'hc2, 8'hff, 1'b1);
        for (int cs = 0; cs < 4; cs++) begin
            for (int re = 0; re < 2; re++) begin
                clk_src_i = cs[1:0];
                reset_pin_en_i = re[0];
                cyc(2);
                chk(pin_count_o, 35 + (cs != 0) + (cs >= 2) + (re == 0));
            end
        end
        $display("fuse and pin count test done");
        tally_and_finish();
    end
endmodule // gpm_port_mode_config_tb
